/* tdc_readout_pkg.sv */
// constants and carrier types for the tdc result and status readout
package tdc_readout_pkg;

  // serial opcodes
  localparam logic [3:0] OP_READ_FAMILY   = 4'hb;
  localparam logic [7:0] OP_READ_ID       = 8'hb7;

  // read addresses
  localparam logic [3:0] ADDR_RESULT_LAST = 4'h3;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam logic [3:0] ADDR_CFG1_ECHO   = 4'h5;
  localparam logic [3:0] ADDR_WAVE_RATIO  = 4'h8;

  // answer lengths in bits
  localparam logic [5:0] LEN_RESULT       = 6'h20;
  localparam logic [5:0] LEN_STATUS       = 6'h10;
  localparam logic [5:0] LEN_BYTE         = 6'h08;
  localparam logic [5:0] LEN_ID           = 6'h38;

  // configuration register 6 field positions
  localparam int CFG6_PORT_ORDER_BIT      = 11;
  localparam int CFG6_FIRE_HI_MSB         = 10;
  localparam int CFG6_FIRE_HI_LSB         = 8;
  localparam int CFG6_USER_ID_MSB         = 7;

  // status word field positions
  localparam int STAT_PTR_LSB             = 0;
  localparam int STAT_HITS1_LSB           = 3;
  localparam int STAT_HITS2_LSB           = 6;
  localparam int STAT_TDC_OVF             = 9;
  localparam int STAT_PRECNT_OVF          = 10;
  localparam int STAT_OPEN                = 11;
  localparam int STAT_SHORT               = 12;
  localparam int STAT_NVM_SINGLE          = 13;
  localparam int STAT_NVM_MULTI           = 14;
  localparam int STAT_NVM_EQUAL           = 15;

  // encodings and limits
  localparam logic [31:0] RESULT_OVERFLOW = 32'hffffffff;
  localparam logic [31:0] RESULT_RESET    = 32'h00000000;
  localparam logic [15:0] UNCAL_LOW_HALF  = 16'h0000;
  localparam logic [6:0]  FIRE_PHASE_MAX  = 7'h0f;
  localparam logic [1:0]  REF_DIV_BY_1    = 2'h0;
  localparam logic [1:0]  REF_DIV_BY_2    = 2'h1;

  // one result delivered by the measuring core
  typedef struct packed {
    logic        mode2;
    logic        calibrate;
    logic        alu_overflow;
    logic [15:0] uncal_count;
    logic [31:0] cal_value;
  } result_in_type;

  // status events, one-cycle pulses, and live levels
  typedef struct packed {
    logic       tdc_overflow;
    logic       precounter_overflow;
    logic       sensor_open;
    logic       sensor_short;
    logic       nvm_single_error;
    logic       nvm_multi_error;
    logic       nvm_matches_config;
    logic [2:0] hits_ch1;
    logic [2:0] hits_ch2;
  } status_in_type;

endpackage

/* tdc_result_status_readout.sv */
// read-side register bank of the tdc with its serial opcode readout
//
// Overview of operation
// R1: cfg6 bit 11 zero gives port order 1..4, one gives 4..1.
// R2: cfg6 bits 10:8 are fire count top bits; above 15 disables phase invert.
// R3: cfg6 bits 7:0 are a free user id byte without effect.
// R4: read opcode 0xBx returns 4, 2 or 1 bytes by address width.
// R5: opcode 0xB7 returns seven id bytes, first to seventh, msb first.
// R6: addresses 0..3 hold four 32-bit 16.16 results.
// R7: status 16 bits: pointer 2:0, ch1 hits 5:3, ch2 hits 8:6.
// R8: status bit 9 set on tdc overflow.
// R9: status bit 10 set on 14-bit precounter overflow in mode 2.
// R10: status bit 11 flags open sensor, bit 12 shorted sensor.
// R11: bits 13/14 flag nvm single/multiple error; bit 15 nvm equals config.
// R12: address 5 returns the top byte of config register 1.
// R13: address 8 returns first-wave width ratio, one integer bit.
// R14: negative results only in mode 1; mode 2 results unsigned.
// R15: mode 1 calibrated overflow writes all ones into the result.
// R16: calibrated results count internal reference periods, divided by 1, 2 or 4.
// R17: results shift out from weight 2^15 down, two's complement.
// R18: uncalibrated mode 1 result: signed 16-bit count high, low half zero.
// R19: temperature discharge times use mode 2 calibrated format.
// R20: width ratio is unsigned 1.7 fixed point, zero to under two.
// R21: reads leave contents unchanged; writes to these locations ignored.
`timescale 1ns/10ps

module tdc_result_status_readout #(
  parameter int RESULT_COUNT = 4
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_n_i,
  // serial command interface
  input  wire logic                          spi_sclk_i,
  input  wire logic                          spi_ss_n_i,
  input  wire logic                          spi_mosi_i,
  output logic                               spi_miso_o,
  // configuration seen by this block
  input  wire logic [11:0]                   cfg6_low_i,
  input  wire logic [3:0]                    fire_count_low_i,
  input  wire logic                          fire_phase_invert_i,
  input  wire logic [7:0]                    cfg1_high_byte_i,
  input  wire logic [55:0]                   user_id_bytes_i,
  input  wire logic [1:0]                    ref_clock_divider_i,
  // measuring core side
  input  wire logic                          measure_start_i,
  input  wire logic                          result_wr_i,
  input  wire tdc_readout_pkg::result_in_type result_i,
  input  wire tdc_readout_pkg::status_in_type status_i,
  input  wire logic [7:0]                    wave_ratio_i,
  input  wire logic                          wave_ratio_wr_i,
  input  wire logic [1:0]                    temp_step_i,
  // derived controls
  output logic [1:0]                         temp_port_o,
  output logic [6:0]                         fire_pulse_count_o,
  output logic                               fire_enable_o,
  output logic                               fire_phase_invert_o,
  output logic                               ref_tick_o,
  output logic [15:0]                        status_o
);

  typedef enum logic [1:0] {
    IDLE_S,
    OPCODE_S,
    SEND_S,
    DONE_S
  } spi_state_type;

  spi_state_type  state_r;
  logic           sclk_q_r;
  logic           sclk_rise;
  logic           sclk_fall;
  logic [7:0]     opcode_r;
  logic [7:0]     opcode_nxt;
  logic [2:0]     op_bits_r;
  logic [55:0]    tx_r;
  logic [5:0]     tx_left_r;
  logic [55:0]    load_data;
  logic [5:0]     load_len;
  logic           load_valid;
  logic [31:0]    result_r [RESULT_COUNT];
  logic [2:0]     result_pointer_r;
  logic [31:0]    result_enc;
  logic [6:0]     sticky_r;
  logic [6:0]     sticky_set;
  logic [5:0]     hits_r;
  logic [7:0]     wave_ratio_r;
  logic [15:0]    status_word;
  logic [1:0]     ref_div_cnt_r;
  logic [6:0]     fire_count;

  assign sclk_rise  = spi_sclk_i & ~sclk_q_r;
  assign sclk_fall  = ~spi_sclk_i & sclk_q_r;
  assign opcode_nxt = {opcode_r[6:0], spi_mosi_i};

  // R14 mode 2 results pass unsigned as delivered
  // R19 temperature times share the mode 2 format
  always_comb begin
    // R15 alu overflow all ones
    if (!result_i.mode2 && result_i.calibrate && result_i.alu_overflow) begin
      result_enc = tdc_readout_pkg::RESULT_OVERFLOW;
    // R18 uncalibrated high half
    end else if (!result_i.mode2 && !result_i.calibrate) begin
      result_enc = {result_i.uncal_count, tdc_readout_pkg::UNCAL_LOW_HALF};
    end else begin
      // R6 calibrated 16.16 value
      result_enc = result_i.cal_value;
    end
  end

  // R6 one register per result
  generate
    for (genvar g = 0; g < RESULT_COUNT; g++) begin : g_result
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          result_r[g] <= tdc_readout_pkg::RESULT_RESET;
        end else if (result_wr_i && result_pointer_r == 3'(g)) begin
          result_r[g] <= result_enc;
        end
      end
    end
  endgenerate

  // R7 pointer to next result register
  // saturates at the count; later writes are dropped, not wrapped
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_pointer_r <= 3'h0;
    end else if (measure_start_i) begin
      result_pointer_r <= 3'h0;
    end else if (result_wr_i && result_pointer_r < 3'(RESULT_COUNT)) begin
      result_pointer_r <= result_pointer_r + 3'h1;
    end
  end

  assign sticky_set = {status_i.nvm_multi_error, status_i.nvm_single_error,
                       status_i.sensor_short, status_i.sensor_open,
                       status_i.precounter_overflow, status_i.tdc_overflow, 1'b0};

  // R8 tdc overflow sticky
  // R9 precounter overflow sticky
  // R10 sensor faults sticky
  // R11 nvm errors sticky; a new event beats the clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sticky_r <= 7'h00;
    end else if (measure_start_i) begin
      sticky_r <= sticky_set;
    end else begin
      sticky_r <= sticky_r | sticky_set;
    end
  end

  // R7 hit counters follow the core
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hits_r <= 6'h00;
    end else begin
      hits_r <= {status_i.hits_ch2, status_i.hits_ch1};
    end
  end

  // R13 width ratio byte
  // R20 unsigned 1.7 kept as delivered
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave_ratio_r <= 8'h00;
    end else if (wave_ratio_wr_i) begin
      wave_ratio_r <= wave_ratio_i;
    end
  end

  always_comb begin
    status_word = 16'h0000;
    // R7 pointer and hit counts
    status_word[tdc_readout_pkg::STAT_PTR_LSB +: 3]   = result_pointer_r;
    status_word[tdc_readout_pkg::STAT_HITS1_LSB +: 3] = hits_r[2:0];
    status_word[tdc_readout_pkg::STAT_HITS2_LSB +: 3] = hits_r[5:3];
    // R8 tdc overflow flag
    status_word[tdc_readout_pkg::STAT_TDC_OVF]        = sticky_r[1];
    // R9 precounter overflow flag
    status_word[tdc_readout_pkg::STAT_PRECNT_OVF]     = sticky_r[2];
    // R10 open sensor flag
    status_word[tdc_readout_pkg::STAT_OPEN]           = sticky_r[3];
    // R10 shorted sensor flag
    status_word[tdc_readout_pkg::STAT_SHORT]          = sticky_r[4];
    // R11 nvm error flags
    status_word[tdc_readout_pkg::STAT_NVM_SINGLE]     = sticky_r[5];
    status_word[tdc_readout_pkg::STAT_NVM_MULTI]      = sticky_r[6];
    // R11 live nvm compare
    status_word[tdc_readout_pkg::STAT_NVM_EQUAL]      = status_i.nvm_matches_config;
  end

  // R7 status word registered for the port
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= 16'h0000;
    end else begin
      status_o <= status_word;
    end
  end

  // decode of a completed opcode; data left aligned for msb-first shifting
  always_comb begin
    load_data  = 56'h0;
    load_len   = tdc_readout_pkg::LEN_BYTE;
    load_valid = (opcode_nxt[7:4] == tdc_readout_pkg::OP_READ_FAMILY);
    // R5 seven id bytes
    if (opcode_nxt == tdc_readout_pkg::OP_READ_ID) begin
      load_data = user_id_bytes_i;
      load_len  = tdc_readout_pkg::LEN_ID;
    // R4 result words four bytes
    // R17 msb of the 16.16 value first
    end else if (opcode_nxt[3:0] <= tdc_readout_pkg::ADDR_RESULT_LAST) begin
      load_data = {result_r[opcode_nxt[1:0]], 24'h0};
      load_len  = tdc_readout_pkg::LEN_RESULT;
    end else if (opcode_nxt[3:0] == tdc_readout_pkg::ADDR_STATUS) begin
      load_data = {status_word, 40'h0};
      load_len  = tdc_readout_pkg::LEN_STATUS;
    // R12 config echo byte
    end else if (opcode_nxt[3:0] == tdc_readout_pkg::ADDR_CFG1_ECHO) begin
      load_data = {cfg1_high_byte_i, 48'h0};
    // R13 width ratio byte
    end else if (opcode_nxt[3:0] == tdc_readout_pkg::ADDR_WAVE_RATIO) begin
      load_data = {wave_ratio_r, 48'h0};
    end
  end

  // edge detector idles low like sclk, so no false rise after reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= spi_sclk_i;
    end
  end

  // serial engine: mosi sampled on rising sclk, miso changes on falling sclk
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= IDLE_S;
      opcode_r   <= 8'h00;
      op_bits_r  <= 3'h0;
      tx_r       <= 56'h0;
      tx_left_r  <= 6'h00;
      spi_miso_o <= 1'b0;
    end else begin
      if (spi_ss_n_i) begin
        state_r    <= IDLE_S;
        op_bits_r  <= 3'h0;
        spi_miso_o <= 1'b0;
      end else begin
        case (state_r)
          IDLE_S: begin
            state_r   <= OPCODE_S;
            op_bits_r <= 3'h0;
            if (sclk_rise) begin
              opcode_r  <= opcode_nxt;
              op_bits_r <= 3'h1;
            end
          end
          OPCODE_S: begin
            if (sclk_rise) begin
              opcode_r  <= opcode_nxt;
              op_bits_r <= op_bits_r + 3'h1;
              if (op_bits_r == 3'h7) begin
                // R4 only read opcodes answer
                // R21 writes leave the bank alone
                state_r   <= load_valid ? SEND_S : DONE_S;
                tx_r      <= load_data;
                tx_left_r <= load_len;
              end
            end
          end
          SEND_S: begin
            // R5 id bytes msb first
            // R17 results msb first
            if (sclk_fall) begin
              spi_miso_o <= tx_r[55];
              tx_r       <= {tx_r[54:0], 1'b0};
              tx_left_r  <= tx_left_r - 6'h01;
            end
            if (tx_left_r == 6'h00 && sclk_rise) begin
              state_r <= DONE_S;
            end
          end
          DONE_S: begin
            // extra clocks of the frame return zero
            if (sclk_fall) begin
              spi_miso_o <= 1'b0;
            end
          end
          default: begin
            state_r <= IDLE_S;
          end
        endcase
      end
    end
  end

  // R16 internal reference tick from the divider setting
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_div_cnt_r <= 2'h0;
      ref_tick_o    <= 1'b0;
    end else begin
      ref_div_cnt_r <= ref_div_cnt_r + 2'h1;
      case (ref_clock_divider_i)
        tdc_readout_pkg::REF_DIV_BY_1: ref_tick_o <= 1'b1;
        tdc_readout_pkg::REF_DIV_BY_2: ref_tick_o <= ref_div_cnt_r[0];
        // settings 2 and 3 both divide by four
        default:                       ref_tick_o <= &ref_div_cnt_r;
      endcase
    end
  end

  // R2 seven-bit count, low bits from register 0
  assign fire_count = {cfg6_low_i[tdc_readout_pkg::CFG6_FIRE_HI_MSB:
                                  tdc_readout_pkg::CFG6_FIRE_HI_LSB], fire_count_low_i};

  // R2 fire count and phase option
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fire_pulse_count_o  <= 7'h00;
      fire_enable_o       <= 1'b0;
      fire_phase_invert_o <= 1'b0;
    end else begin
      fire_pulse_count_o  <= fire_count;
      fire_enable_o       <= (fire_count != 7'h00);
      fire_phase_invert_o <= fire_phase_invert_i &&
                             (fire_count <= tdc_readout_pkg::FIRE_PHASE_MAX);
    end
  end

  // R3 cfg6 bits 7:0 reach no logic by intent
  // R1 port order from cfg6 bit 11
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_port_o <= 2'h0;
    end else if (cfg6_low_i[tdc_readout_pkg::CFG6_PORT_ORDER_BIT]) begin
      temp_port_o <= 2'h3 - temp_step_i;
    end else begin
      temp_port_o <= temp_step_i;
    end
  end

endmodule // tdc_result_status_readout

/* tdc_readout_monitor.sv */
// port assertions for the tdc readout, bound into the design
`timescale 1ns/10ps

module tdc_readout_monitor #(
  parameter int RESULT_COUNT = 4
) (
  input wire logic                           sys_clk_i,
  input wire logic                           rst_n_i,
  input wire logic                           spi_ss_n_i,
  input wire logic                           spi_miso_o,
  input wire logic [11:0]                    cfg6_low_i,
  input wire logic [3:0]                     fire_count_low_i,
  input wire logic                           fire_phase_invert_i,
  input wire logic [1:0]                     ref_clock_divider_i,
  input wire tdc_readout_pkg::status_in_type status_i,
  input wire logic [1:0]                     temp_step_i,
  input wire logic [1:0]                     temp_port_o,
  input wire logic [6:0]                     fire_pulse_count_o,
  input wire logic                           fire_phase_invert_o,
  input wire logic                           ref_tick_o,
  input wire logic [15:0]                    status_o
);
  logic up_r;

  // gates $past until one real edge has passed since reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_r <= 1'b0;
    end else begin
      up_r <= 1'b1;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  port_order_a: assert property (up_r |-> temp_port_o ==
    ($past(cfg6_low_i[11]) ? 2'h3 - $past(temp_step_i) : $past(temp_step_i)))
    else $error("temp port order wrong");
  fire_count_a: assert property (up_r |-> fire_pulse_count_o ==
    {$past(cfg6_low_i[10:8]), $past(fire_count_low_i)}) else $error("fire count wrong");
  phase_limit_a: assert property (up_r |-> fire_phase_invert_o ==
    ($past(fire_phase_invert_i) && fire_pulse_count_o <= 7'h0f)) else $error("phase bad");
  tdc_ovf_a: assert property (status_i.tdc_overflow |-> ##[1:2] status_o[9])
    else $error("tdc overflow flag missing");
  precnt_ovf_a: assert property (status_i.precounter_overflow |-> ##[1:2] status_o[10])
    else $error("precounter flag missing");
  hit_count_a: assert property ((up_r && $stable(status_i.hits_ch1))[*3] |->
    status_o[5:3] == status_i.hits_ch1) else $error("hit count field wrong");
  tick_half_a: assert property ((up_r && ref_clock_divider_i == 2'h1)[*4] |->
    ref_tick_o != $past(ref_tick_o)) else $error("half rate tick wrong");
  miso_idle_a: assert property ((up_r && spi_ss_n_i)[*3] |-> !spi_miso_o)
    else $error("miso active outside frame");

  cover property (status_o[9] && status_o[10]);
  cover property (!spi_ss_n_i && spi_miso_o);
  cover property (cfg6_low_i[11] && temp_port_o == 2'h3);
endmodule // tdc_readout_monitor

bind tdc_result_status_readout tdc_readout_monitor #(.RESULT_COUNT(RESULT_COUNT)) mon (
  .sys_clk_i, .rst_n_i, .spi_ss_n_i, .spi_miso_o, .cfg6_low_i, .fire_count_low_i,
  .fire_phase_invert_i, .ref_clock_divider_i, .status_i, .temp_step_i, .temp_port_o,
  .fire_pulse_count_o, .fire_phase_invert_o, .ref_tick_o, .status_o);

/* host_spi_model.sv */
// host side of the serial command link: frames out, answers in
`timescale 1ns/10ps

module host_spi_model (
  input  wire logic sys_clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      ss_n_o,
  output logic      mosi_o
);
  initial begin
    {sclk_o, ss_n_o, mosi_o} = 3'h2;
  end

  // opcode then data msb first, answer taken msb first
  task automatic xfer(input logic [7:0] op, input int nbits, input logic [55:0] wdata,
                      output logic [55:0] rdata);
    rdata = '0;
    @(posedge sys_clk_i);
    #1;
    ss_n_o = 1'b0;
    mosi_o = op[7];
    // slow edges: four cycles a phase keeps the sync sampler comfortable
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < nbits + 8; i++) begin
      repeat (4) @(posedge sys_clk_i);
      #1;
      if (i >= 8) rdata = {rdata[54:0], miso_i};
      sclk_o = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      #1;
      sclk_o = 1'b0;
      mosi_o = (i < 7) ? op[6 - i] : (i + 1 < nbits + 8) ? wdata[nbits + 6 - i] : ~mosi_o;
    end
    repeat (2) @(posedge sys_clk_i);
    #1;
    ss_n_o = 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask
endmodule // host_spi_model

/* testbench.sv */
// self-checking bench for the tdc readout register bank
`timescale 1ns/10ps

module testbench;
  logic        sys_clk_i, rst_n_i, sclk, ss_n, mosi, miso;
  logic        phase_req, meas, res_wr, ratio_wr, fire_en, phase_o, tick;
  logic [11:0] cfg6;
  logic [3:0]  fire_lo;
  logic [7:0]  ratio;
  logic [1:0]  div, step, port;
  logic [6:0]  fire_cnt;
  logic [15:0] stat_o;
  logic [55:0] rd;
  int          mismatches, compares, ticks;
  tdc_readout_pkg::result_in_type res_in;
  tdc_readout_pkg::status_in_type stat_in;
  logic [31:0] res_exp [4] = '{32'hfffe8000, 32'hffffffff, 32'h81230000, 32'h9abc0001};
  logic [6:0]  counts [4] = '{7'h00, 7'h0f, 7'h10, 7'h7f};

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  tdc_result_status_readout uut (
    .sys_clk_i, .rst_n_i, .spi_sclk_i(sclk), .spi_ss_n_i(ss_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .cfg6_low_i(cfg6), .fire_count_low_i(fire_lo),
    .fire_phase_invert_i(phase_req), .cfg1_high_byte_i(8'h3c),
    .user_id_bytes_i(56'h0123456789abcd), .ref_clock_divider_i(div),
    .measure_start_i(meas), .result_wr_i(res_wr), .result_i(res_in), .status_i(stat_in),
    .wave_ratio_i(ratio), .wave_ratio_wr_i(ratio_wr), .temp_step_i(step),
    .temp_port_o(port), .fire_pulse_count_o(fire_cnt), .fire_enable_o(fire_en),
    .fire_phase_invert_o(phase_o), .ref_tick_o(tick), .status_o(stat_o));

  host_spi_model host (.sys_clk_i, .miso_i(miso), .sclk_o(sclk), .ss_n_o(ss_n),
    .mosi_o(mosi));

  task automatic check(input string what, input logic [55:0] exp, input logic [55:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick_wait(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick_wait(1);
    s = 1'b0;
    tick_wait(1);
  endtask

  task automatic rd_chk(input logic [7:0] op, input int n, input logic [55:0] exp);
    host.xfer(op, n, 56'h0, rd);
    check($sformatf("read op %h", op), exp, rd);
  endtask

  task automatic summarize();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    tick_wait(40000);
    mismatches++;
    summarize();
  end

  initial begin
    {rst_n_i, meas, res_wr, ratio_wr, phase_req} = 5'h01;
    {cfg6, fire_lo, div, step, ratio} = '0;
    res_in = '0;
    stat_in = '0;
    tick_wait(20);
    rst_n_i = 1'b1;
    tick_wait(2);
    for (int k = 0; k < 4; k++) begin
      {cfg6[10:8], fire_lo} = counts[k];
      tick_wait(2);
      check("fire enable", counts[k] != 7'h00, fire_en);
      check("phase invert", counts[k] <= 7'h0f, phase_o);
      check("fire count", counts[k], fire_cnt);
    end
    for (int k = 0; k < 8; k++) begin
      {cfg6[11], step} = k[2:0];
      tick_wait(2);
      check("temp port", k[2] ? 2'h3 - k[1:0] : k[1:0], port);
    end
    for (int d = 0; d < 3; d++) begin
      div = d[1:0];
      tick_wait(8);
      ticks = 0;
      repeat (8) begin
        tick_wait(1);
        ticks += tick;
      end
      check("ref ticks", 8 >> d, ticks);
    end
    pulse(meas);
    res_in = '{1'b0, 1'b1, 1'b0, 16'h0, 32'hfffe8000};
    pulse(res_wr);
    res_in = '{1'b0, 1'b1, 1'b1, 16'h0, 32'h12345678};
    pulse(res_wr);
    res_in = '{1'b0, 1'b0, 1'b0, 16'h8123, 32'h5555aaaa};
    pulse(res_wr);
    res_in = '{1'b1, 1'b1, 1'b0, 16'h0, 32'h9abc0001};
    pulse(res_wr);
    for (int k = 0; k < 4; k++) rd_chk({4'hb, k[3:0]}, 32, res_exp[k]);
    stat_in = {7'h55, 3'h5, 3'h2};
    tick_wait(1);
    stat_in = {7'h01, 3'h5, 3'h2};
    tick_wait(3);
    check("status odd flags", 16'haaac, stat_o);
    stat_in = {7'h2a, 3'h5, 3'h2};
    tick_wait(1);
    stat_in = {7'h01, 3'h5, 3'h2};
    tick_wait(3);
    check("status out", 16'hfeac, stat_o);
    rd_chk(8'hb4, 16, 16'hfeac);
    rd_chk(8'hb4, 16, 16'hfeac);
    rd_chk(8'hb5, 8, 8'h3c);
    ratio = 8'hff;
    pulse(ratio_wr);
    rd_chk(8'hb8, 8, 8'hff);
    rd_chk(8'hb7, 56, 56'h0123456789abcd);
    host.xfer(8'h80, 32, 56'hdeadbeef, rd);
    check("write answer", 56'h0, rd);
    rd_chk(8'hb0, 32, 32'hfffe8000);
    stat_in = {7'h41, 3'h5, 3'h2};
    meas = 1'b1;
    tick_wait(1);
    stat_in = {7'h01, 3'h5, 3'h2};
    meas = 1'b0;
    tick_wait(3);
    check("status cleared", 16'h82a8, stat_o);
    rst_n_i = 1'b0;
    tick_wait(2);
    check("reset status", 16'h0, stat_o);
    rst_n_i = 1'b1;
    tick_wait(2);
    rd_chk(8'hb0, 32, 32'h0);
    summarize();
  end
endmodule // testbench
